// ### logic/ipm_pkg.sv
// package: register map, field positions, codes and timing for the power-mode sequencer
package ipm_pkg;
  // ===========================================================
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_ISDN_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_CMD_CHAN   = 8'h04;
  localparam logic [7:0] ADDR_USB_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_PWR_CTRL   = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_STATUS     = 8'h14;
  localparam logic [7:0] ADDR_EVENT      = 8'h18;
  // ===========================================================
  // isdn control fields
  localparam int ISDN_LAYER1_SW   = 0;
  localparam int ISDN_PWR_DOWN    = 1;
  localparam int ISDN_CLK_STOP    = 2;
  localparam int ISDN_LVL_DIS     = 3;
  localparam int ISDN_TX_DIS      = 4;
  localparam int ISDN_TRX_DIS     = 5;
  localparam int ISDN_BUS_DISC    = 6;
  localparam int ISDN_UP_LOW      = 7;
  localparam logic [7:0] ISDN_CTRL_RST = 8'h00;
  // usb control fields
  localparam int USB_CLK_EN       = 0;
  localparam int USB_SW_RST       = 1;
  localparam int USB_INIT_BUSY    = 2;
  localparam int USB_EP_DONE      = 3;
  // power control fields
  localparam int PWR_PLL_EN       = 0;
  localparam int PWR_PLL_SEL      = 1;
  localparam int PWR_IDLE_EN      = 2;
  localparam int PWR_IDLE_START   = 3;
  localparam int PWR_SUSP_EN      = 4;
  localparam int PWR_SUSP_START   = 5;
  // wake control fields
  localparam int WAKE_GLOBAL      = 0;
  localparam int WAKE_USB         = 1;
  localparam int WAKE_IRQ0        = 2;
  localparam int WAKE_LEVEL       = 3;
  localparam int WAKE_CMD         = 4;
  localparam int WAKE_REMOTE      = 5;
  // event flag fields
  localparam int EVT_LEVEL        = 0;
  localparam int EVT_CMD_CHANGE   = 1;
  localparam int EVT_IRQ0         = 2;
  localparam int EVT_AWAKE        = 3;
  localparam int EVT_USB_RESUME   = 4;
  // ===========================================================
  // command channel codes
  localparam logic [3:0] CMD_DEACT_UP    = 4'hF;
  localparam logic [3:0] IND_POWER_UP    = 4'h7;
  localparam logic [3:0] CMD_CLOCK_REQ   = 4'h0;
  localparam logic [3:0] CMD_ACT_REQ     = 4'h8;
  localparam logic [3:0] CMD_CHAN_RST    = 4'h7;
  // ===========================================================
  // timing
  localparam int CLK_MHZ           = 200;
  localparam int RESET_TIME_US     = 4000;
  localparam int OSC_STABLE_US     = 4000;
  localparam int USB_IDLE_US       = 3000;
  localparam int RESET_CYCLES      = RESET_TIME_US * CLK_MHZ;
  localparam int OSC_CYCLES        = OSC_STABLE_US * CLK_MHZ;
  localparam int USB_IDLE_CYCLES   = USB_IDLE_US * CLK_MHZ + 1;
  localparam int USB_RST_CYCLES    = 16;
  localparam int MACHINE_CYCLES    = 12;
  localparam logic [15:0] NMI_VECTOR = 16'h007B;
  // ===========================================================
  typedef enum logic [2:0] {
    IPM_RESET, IPM_ACTIVE, IPM_IDLE, IPM_SUSPEND, IPM_WAKE_WAIT
  } ipm_state_e;
endpackage

// ### logic/ipm_sequencer.sv
// power-mode sequencer: isdn local power down and chip-wide reset/active/idle/suspend
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
// What this block does
// - layer-1 enabled: writing deactivation code 1111 enters isdn local power down, s-bus silent
// - layer-1 software controlled: power-down command bit enters isdn local power down
// - clock-stop clear: clocks stay on; indication 1111 down, 0111 up
// - clock-stop set: all isdn clocks stop, only level detector stays active
// - level-detect enabled: exchange activation gives clock immediately
// - level-detect disabled: line activity sets flag; software clears disable to reactivate
// - transmitter disable turns off only the s transmitter
// - transceiver disable turns all off, clock pins become inputs, level detect only if enabled
// - terminal-bus disconnect isolates external devices from the terminal bus
// - upstream-low bit drives upstream data line low to force external clocking
// - 4 ms hardware reset initialises all but usb core; usb interface and mmu reset
// - after reset run at crystal and spend one machine cycle clearing registers
// - usb software reset resets usb; completion clears bit and sets init busy
// - endpoint done bit clears init busy, ending initialisation
// - before idle: usb clock off, pll bypass, pll off; bypass switch glitch-free
// - idle ends on enabled interrupt or 4 ms reset; resume after idle instruction
// - after idle interrupt exit usb configuration is retained
// - suspend: enabled wake sources drive nmi at 007B without flags; flags are set only in active and idle
// - on pin, command or level wake wait 4 ms then switch crystal clock to core
// - usb enters suspend after more than 3 ms without bus activity
module ipm_sequencer #(
  parameter int RESET_CNT   = ipm_pkg::RESET_CYCLES,
  parameter int OSC_CNT     = ipm_pkg::OSC_CYCLES,
  parameter int USB_IDLE_CNT = ipm_pkg::USB_IDLE_CYCLES
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // line and pin inputs (asynchronous)
  input  wire logic        i_line_activity,
  input  wire logic        i_usb_bus_activity,
  input  wire logic        i_usb_rx_powered,
  input  wire logic        i_external_irq_zero_pin_n,
  input  wire logic        i_external_awake_pin_n,
  input  wire logic [3:0]  i_rx_command_code,
  input  wire logic        i_exchange_activation,
  input  wire logic        i_data_bit_clock,
  input  wire logic        i_frame_sync,
  // interrupt request from the core to end idle
  input  wire logic        i_core_irq,
  // isdn outputs
  output logic             o_isdn_power_down,
  output logic             o_isdn_clk_en,
  output logic             o_level_detect_en,
  output logic             o_s_tx_en,
  output logic             o_s_rx_en,
  output logic             o_s_signal_en,
  output logic [3:0]       o_tx_indication,
  output logic             o_data_bit_clock,
  output logic             o_data_bit_clock_oe,
  output logic             o_frame_sync,
  output logic             o_frame_sync_oe,
  output logic             o_term_bus_en,
  output logic             o_upstream_data_line,
  output logic             o_upstream_data_line_oe,
  // chip-wide outputs
  output logic             o_chip_reset,
  output logic             o_usb_if_reset,
  output logic             o_usb_core_reset,
  output logic             o_usb_clk_en,
  output logic             o_pll_en,
  output logic             o_core_pll_sel,
  output logic             o_core_clk_en,
  output logic             o_osc_en,
  output logic             o_usb_suspended,
  output logic             o_nmi,
  output logic [15:0]      o_nmi_vector,
  output logic [2:0]       o_power_state
);
  import ipm_pkg::*;

  initial begin
    if (RESET_CNT < 1 || OSC_CNT < 1 || USB_IDLE_CNT < 2) begin
      $error("ipm_sequencer: counts must be positive");
    end
  end

  // ===========================================================
  // input synchronisers
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] nxt_sync1;
  logic [3:0]       code1_ff;
  logic [3:0]       code2_ff;
  logic [3:0]       code3_ff;

  always_comb begin
    nxt_sync1 = {i_line_activity, i_usb_bus_activity, i_usb_rx_powered,
                 i_external_irq_zero_pin_n, i_external_awake_pin_n,
                 i_exchange_activation, i_data_bit_clock, i_frame_sync, i_core_irq};
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sync1_ff <= 9'h030; // pins idle high
      sync2_ff <= 9'h030;
      code1_ff <= 4'h0;
      code2_ff <= 4'h0;
      code3_ff <= 4'h0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= sync1_ff;
      code1_ff <= i_rx_command_code;
      code2_ff <= code1_ff;
      code3_ff <= code2_ff;
    end
  end

  logic s_line, s_usb_act, s_rx_pwr, s_irq0, s_awake, s_exch, s_dcl, s_fsc, s_irq;
  assign s_line    = sync2_ff[8];
  assign s_usb_act = sync2_ff[7];
  assign s_rx_pwr  = sync2_ff[6];
  assign s_irq0    = ~sync2_ff[5];
  assign s_awake   = ~sync2_ff[4];
  assign s_exch    = sync2_ff[3];
  assign s_dcl     = sync2_ff[2];
  assign s_fsc     = sync2_ff[1];
  assign s_irq     = sync2_ff[0];

  // ===========================================================
  // registers and sequencer state
  logic [7:0]  isdn_ff, nxt_isdn;
  logic [3:0]  cmd_ff, nxt_cmd;
  logic [3:0]  usb_ff, nxt_usb;
  logic [5:0]  pwr_ff, nxt_pwr;
  logic [5:0]  wake_ff, nxt_wake;
  logic [4:0]  evt_ff, nxt_evt;
  logic        pd_ff, nxt_pd;
  logic        nmi_ff, nxt_nmi;
  logic        usbsus_ff, nxt_usbsus;
  logic        wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [31:0] ucnt_ff, nxt_ucnt;
  logic [4:0]  rcnt_ff, nxt_rcnt;
  ipm_state_e  st_ff, nxt_st;

  // byte-lane write merge for low byte (all writable registers are at most 8 bits)
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    wr_byte = be[0] ? wd[7:0] : old;
  endfunction

  logic wr_acc, rd_acc, cmd_change, wake_any, usb_wake;
  assign wr_acc = i_avs_write & wait_ff;
  assign rd_acc = i_avs_read & ~wait_ff;
  assign cmd_change = (code3_ff != code2_ff);

  always_comb begin
    logic [7:0] wb;
    wb         = wr_byte(8'h00, i_avs_writedata, i_avs_byteenable);
    nxt_isdn   = isdn_ff;
    nxt_cmd    = cmd_ff;
    nxt_usb    = usb_ff;
    nxt_pwr    = pwr_ff;
    nxt_wake   = wake_ff;
    nxt_evt    = evt_ff;
    nxt_pd     = pd_ff;
    nxt_nmi    = 1'b0;
    nxt_usbsus = usbsus_ff;
    nxt_st     = st_ff;
    nxt_cnt    = cnt_ff;
    nxt_ucnt   = ucnt_ff;
    nxt_rcnt   = rcnt_ff;
    nxt_rdata  = rdata_ff;
    // one-cycle wait state: waitrequest drops for one cycle per request
    nxt_wait   = (i_avs_read | i_avs_write) & ~wait_ff;
    wake_any   = 1'b0;
    usb_wake   = wake_ff[WAKE_USB] & s_usb_act & s_rx_pwr;

    // register writes
    if (wr_acc && i_avs_byteenable[0]) begin
      case (i_avs_address)
        ADDR_ISDN_CTRL: nxt_isdn = wb;
        ADDR_CMD_CHAN:  nxt_cmd  = wb[3:0];
        ADDR_USB_CTRL: begin
          nxt_usb[USB_CLK_EN] = wb[USB_CLK_EN];
          if (wb[USB_SW_RST]) begin
            nxt_usb[USB_SW_RST] = 1'b1;
            nxt_rcnt = 5'(USB_RST_CYCLES);
          end
          if (wb[USB_EP_DONE] && usb_ff[USB_INIT_BUSY]) begin
            nxt_usb[USB_INIT_BUSY] = 1'b0;
          end
        end
        ADDR_PWR_CTRL: begin
          nxt_pwr = wb[5:0];
          // suspend start only counts when enable was set by an earlier access
          nxt_pwr[PWR_SUSP_START] = wb[PWR_SUSP_START] & pwr_ff[PWR_SUSP_EN];
          nxt_pwr[PWR_IDLE_START] = wb[PWR_IDLE_START] & pwr_ff[PWR_IDLE_EN];
        end
        ADDR_WAKE_CTRL: nxt_wake = wb[5:0];
        ADDR_EVENT:     nxt_evt  = evt_ff & ~wb[4:0];
        default: ;
      endcase
    end

    // usb software reset countdown then init busy
    if (usb_ff[USB_SW_RST] && rcnt_ff != 5'h00) begin
      nxt_rcnt = rcnt_ff - 5'h01;
    end else if (usb_ff[USB_SW_RST]) begin
      nxt_usb[USB_SW_RST]    = 1'b0;
      nxt_usb[USB_INIT_BUSY] = 1'b1;
    end

    // isdn local power down entry and exit
    if (!isdn_ff[ISDN_LAYER1_SW]) begin
      nxt_pd = (nxt_cmd == CMD_DEACT_UP);
    end else begin
      nxt_pd = nxt_isdn[ISDN_PWR_DOWN];
    end
    if (s_exch && !isdn_ff[ISDN_LVL_DIS]) begin
      nxt_pd = 1'b0;
    end

    // usb bus idle timer
    if (s_usb_act) begin
      nxt_ucnt   = 32'h0;
      nxt_usbsus = 1'b0;
    end else if (ucnt_ff >= 32'(USB_IDLE_CNT)) begin
      nxt_usbsus = 1'b1;
    end else begin
      nxt_ucnt = ucnt_ff + 32'h1;
    end

    // chip state machine
    case (st_ff)
      IPM_RESET: begin
        // reset held, then one machine cycle of register clearing
        if (cnt_ff >= 32'(RESET_CNT + MACHINE_CYCLES)) begin
          nxt_st  = IPM_ACTIVE;
          nxt_cnt = 32'h0;
        end else begin
          nxt_cnt = cnt_ff + 32'h1;
        end
      end
      IPM_ACTIVE: begin
        if (pwr_ff[PWR_SUSP_START]) begin
          nxt_st = IPM_SUSPEND;
          nxt_pwr[PWR_SUSP_START] = 1'b0;
          nxt_pwr[PWR_SUSP_EN]    = 1'b0;
          nxt_pwr[PWR_IDLE_START] = 1'b0;
        end else if (pwr_ff[PWR_IDLE_START]) begin
          nxt_st = IPM_IDLE;
          nxt_pwr[PWR_IDLE_START] = 1'b0;
        end
      end
      IPM_IDLE: begin
        if (s_irq || evt_ff != 5'h00) begin
          nxt_st = IPM_ACTIVE;
        end
      end
      IPM_SUSPEND: begin
        wake_any = wake_ff[WAKE_GLOBAL] & wake_ff[WAKE_REMOTE] &
                   ((wake_ff[WAKE_IRQ0] & s_irq0) |
                    (wake_ff[WAKE_LEVEL] & s_line) |
                    (wake_ff[WAKE_CMD] & (s_awake | cmd_change)));
        if (wake_any || (wake_ff[WAKE_GLOBAL] && usb_wake)) begin
          nxt_st  = IPM_WAKE_WAIT;
          nxt_cnt = 32'h0;
        end
      end
      IPM_WAKE_WAIT: begin
        if (cnt_ff >= 32'(OSC_CNT - 1)) begin
          nxt_st  = IPM_ACTIVE;
          nxt_nmi = 1'b1;
          nxt_cnt = 32'h0;
        end else begin
          nxt_cnt = cnt_ff + 32'h1;
        end
      end
      default: nxt_st = IPM_RESET;
    endcase

    // event flags only in active and idle; set wins over software clear
    if (st_ff == IPM_ACTIVE || st_ff == IPM_IDLE) begin
      if (s_line && isdn_ff[ISDN_LVL_DIS]) nxt_evt[EVT_LEVEL] = 1'b1;
      if (cmd_change) nxt_evt[EVT_CMD_CHANGE] = 1'b1;
      if (s_irq0) nxt_evt[EVT_IRQ0] = 1'b1;
      if (s_awake) nxt_evt[EVT_AWAKE] = 1'b1;
      if (s_usb_act && usbsus_ff) nxt_evt[EVT_USB_RESUME] = 1'b1;
    end

    // read mux
    if (rd_acc) begin
      case (i_avs_address)
        ADDR_ISDN_CTRL: nxt_rdata = {24'h0, isdn_ff};
        ADDR_CMD_CHAN:  nxt_rdata = {28'h0, cmd_ff};
        ADDR_USB_CTRL:  nxt_rdata = {28'h0, usb_ff};
        ADDR_PWR_CTRL:  nxt_rdata = {26'h0, pwr_ff};
        ADDR_WAKE_CTRL: nxt_rdata = {26'h0, wake_ff};
        ADDR_STATUS:    nxt_rdata = {20'h0, code2_ff, usbsus_ff, pd_ff,
                                     3'(st_ff), o_tx_indication[2:0]};
        ADDR_EVENT:     nxt_rdata = {27'h0, evt_ff};
        default:        nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      isdn_ff   <= ISDN_CTRL_RST;
      cmd_ff    <= CMD_CHAN_RST;
      usb_ff    <= 4'h0;
      pwr_ff    <= 6'h00;
      wake_ff   <= 6'h00;
      evt_ff    <= 5'h00;
      pd_ff     <= 1'b0;
      nmi_ff    <= 1'b0;
      usbsus_ff <= 1'b0;
      wait_ff   <= 1'b0;
      rdata_ff  <= 32'h0;
      cnt_ff    <= 32'h0;
      ucnt_ff   <= 32'h0;
      rcnt_ff   <= 5'h00;
      st_ff     <= IPM_RESET;
    end else begin
      isdn_ff   <= nxt_isdn;
      cmd_ff    <= nxt_cmd;
      usb_ff    <= nxt_usb;
      pwr_ff    <= nxt_pwr;
      wake_ff   <= nxt_wake;
      evt_ff    <= nxt_evt;
      pd_ff     <= nxt_pd;
      nmi_ff    <= nxt_nmi;
      usbsus_ff <= nxt_usbsus;
      wait_ff   <= nxt_wait;
      rdata_ff  <= nxt_rdata;
      cnt_ff    <= nxt_cnt;
      ucnt_ff   <= nxt_ucnt;
      rcnt_ff   <= nxt_rcnt;
      st_ff     <= nxt_st;
    end
  end

  // ===========================================================
  // registered outputs
  logic       trx_off, clk_stopped, run_state;
  assign trx_off     = isdn_ff[ISDN_TRX_DIS];
  assign clk_stopped = pd_ff & isdn_ff[ISDN_CLK_STOP];
  assign run_state   = (st_ff == IPM_ACTIVE) || (st_ff == IPM_IDLE);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_avs_readdata          <= 32'h0;
      o_avs_waitrequest       <= 1'b1;
      o_isdn_power_down       <= 1'b0;
      o_isdn_clk_en           <= 1'b0;
      o_level_detect_en       <= 1'b0;
      o_s_tx_en               <= 1'b0;
      o_s_rx_en               <= 1'b0;
      o_s_signal_en           <= 1'b0;
      o_tx_indication         <= IND_POWER_UP;
      o_data_bit_clock        <= 1'b0;
      o_data_bit_clock_oe     <= 1'b0;
      o_frame_sync            <= 1'b0;
      o_frame_sync_oe         <= 1'b0;
      o_term_bus_en           <= 1'b0;
      o_upstream_data_line    <= 1'b0;
      o_upstream_data_line_oe <= 1'b0;
      o_chip_reset            <= 1'b1;
      o_usb_if_reset          <= 1'b1;
      o_usb_core_reset        <= 1'b0;
      o_usb_clk_en            <= 1'b0;
      o_pll_en                <= 1'b0;
      o_core_pll_sel          <= 1'b0;
      o_core_clk_en           <= 1'b1;
      o_osc_en                <= 1'b1;
      o_usb_suspended         <= 1'b0;
      o_nmi                   <= 1'b0;
      o_nmi_vector            <= NMI_VECTOR;
      o_power_state           <= 3'h0;
    end else begin
      o_avs_readdata          <= nxt_rdata;
      o_avs_waitrequest       <= ~nxt_wait;
      o_isdn_power_down       <= pd_ff;
      o_isdn_clk_en           <= ~clk_stopped & ~trx_off & run_state;
      o_level_detect_en       <= pd_ff | ~isdn_ff[ISDN_LVL_DIS];
      o_s_tx_en               <= ~isdn_ff[ISDN_TX_DIS] & ~trx_off & ~pd_ff;
      o_s_rx_en               <= ~trx_off & ~clk_stopped;
      o_s_signal_en           <= ~pd_ff & ~trx_off;
      o_tx_indication         <= pd_ff ? CMD_DEACT_UP : IND_POWER_UP;
      o_data_bit_clock        <= s_dcl;
      o_data_bit_clock_oe     <= ~trx_off & ~clk_stopped;
      o_frame_sync            <= s_fsc;
      o_frame_sync_oe         <= ~trx_off & ~clk_stopped;
      o_term_bus_en           <= ~isdn_ff[ISDN_BUS_DISC];
      o_upstream_data_line    <= 1'b0;
      o_upstream_data_line_oe <= isdn_ff[ISDN_UP_LOW];
      o_chip_reset            <= (st_ff == IPM_RESET);
      o_usb_if_reset          <= (st_ff == IPM_RESET);
      o_usb_core_reset        <= usb_ff[USB_SW_RST];
      o_usb_clk_en            <= usb_ff[USB_CLK_EN] & run_state;
      o_pll_en                <= pwr_ff[PWR_PLL_EN] & run_state;
      o_core_pll_sel          <= pwr_ff[PWR_PLL_SEL] & pwr_ff[PWR_PLL_EN] & run_state;
      o_core_clk_en           <= (st_ff == IPM_ACTIVE) || (st_ff == IPM_RESET);
      o_osc_en                <= (st_ff != IPM_SUSPEND);
      o_usb_suspended         <= usbsus_ff;
      o_nmi                   <= nmi_ff;
      o_nmi_vector            <= NMI_VECTOR;
      o_power_state           <= 3'(st_ff);
    end
  end
endmodule

// ### dv/ipm_line_model.sv
// line-side partner: s-bus activity, downstream command code, terminal-bus clocks
`timescale 1ns/1ps
module ipm_line_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_act,
  input  wire logic [3:0] i_code,
  output logic            o_line,
  output logic            o_dcl,
  output logic            o_fsc,
  output logic [3:0]      o_code
);
  logic [2:0] cnt = 3'h0;
  initial {o_line, o_dcl, o_fsc, o_code} = 7'h00;
  // clocks toggle only while i_act is high, with back-to-back 8-cycle frames, and rest low while i_act is low
  always @(posedge i_sys_clk) begin
    cnt <= i_act ? cnt + 3'h1 : 3'h0;
    o_dcl <= i_act & ~o_dcl;
    o_fsc <= i_act && cnt == 3'h0;
    o_line <= i_act;
    o_code <= i_code;
  end
endmodule

// ### dv/ipm_sequencer_sva.sv
// checker: port-level properties of the power-mode sequencer
`timescale 1ns/1ps
module ipm_sequencer_sva #(
  parameter int OSC_CNT = 20
) (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_avs_read,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_isdn_power_down,
  input wire logic [3:0]  o_tx_indication,
  input wire logic        o_s_signal_en,
  input wire logic        o_s_rx_en,
  input wire logic        o_data_bit_clock_oe,
  input wire logic        o_frame_sync_oe,
  input wire logic        o_upstream_data_line,
  input wire logic        o_upstream_data_line_oe,
  input wire logic        o_usb_if_reset,
  input wire logic        o_osc_en,
  input wire logic        o_nmi,
  input wire logic [15:0] o_nmi_vector,
  input wire logic [2:0]  o_power_state
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // ===========================================================
  // wake sequence steps
  sequence s_wait_hold;
    (o_power_state == 3'h4) [*8];
  endsequence
  sequence s_back_active;
    ##[1:40] (o_power_state == 3'h1);
  endsequence
  chk_read_answer: assert property ($rose(i_avs_read) |-> ##[1:3] !o_avs_waitrequest)
    else $error("read not answered in time");
  chk_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  chk_pd_code: assert property (o_tx_indication == (o_isdn_power_down ? 4'hF : 4'h7))
    else $error("indication code wrong");
  chk_pd_silent: assert property (o_isdn_power_down |-> !o_s_signal_en)
    else $error("s bus signal in power down");
  chk_trx_pins: assert property (!o_s_rx_en |-> !o_data_bit_clock_oe && !o_frame_sync_oe)
    else $error("clock pins driven with transceiver off");
  chk_up_low: assert property (o_upstream_data_line_oe |-> !o_upstream_data_line)
    else $error("upstream line not low");
  chk_nmi_vec: assert property (o_nmi |-> o_nmi_vector == 16'h007B)
    else $error("nmi vector wrong");
  chk_susp_osc: assert property (o_power_state == 3'h3 |-> !o_osc_en)
    else $error("oscillator on in suspend");
  chk_wake_seq: assert property ($rose(o_power_state == 3'h4) |-> s_wait_hold ##0 s_back_active)
    else $error("wake wait sequence wrong");
  chk_state_step: assert property (o_power_state != $past(o_power_state) |->
    {$past(o_power_state), o_power_state} inside {6'o01, 6'o12, 6'o21, 6'o13, 6'o34, 6'o41})
    else $error("illegal state change");
  chk_usb_if_rst: assert property (o_power_state == 3'h0 |-> o_usb_if_reset)
    else $error("usb interface not in reset");
endmodule
bind ipm_sequencer ipm_sequencer_sva #(.OSC_CNT(OSC_CNT)) u_sva (.*);

// ### dv/tb.sv
// testbench: register-driven scenarios of the power-mode sequencer
`timescale 1ns/1ps
module tb;
  import ipm_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, irq = 0, act = 0, pin0_n = 1, usb_act = 0, rxpw = 1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [3:0] code = 4'h0, mcode, ind, r;
  logic [2:0] pst;
  logic [15:0] vec;
  logic wreq, pd, cke, txe, rxe, sig, dclo, fsco, tbe, upl, upo, ucr, osc, nmi;
  logic line, data_bit_clock, frame_sync, usus, psel, cce;
  int mismatches = 0, samples_checked = 0;
  logic [31:0] expq[$];
  always #2.5 clk = ~clk;
  ipm_line_model u_line (.i_sys_clk(clk), .i_act(act), .i_code(code), .o_line(line),
    .o_dcl(data_bit_clock), .o_fsc(frame_sync), .o_code(mcode));
  ipm_sequencer #(.RESET_CNT(20), .OSC_CNT(20), .USB_IDLE_CNT(30)) u_dut (
    .i_sys_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_line_activity(line),
    .i_usb_bus_activity(usb_act), .i_usb_rx_powered(rxpw),
    .i_external_irq_zero_pin_n(pin0_n),
    .i_external_awake_pin_n(1'b1), .i_rx_command_code(mcode), .i_exchange_activation(line),
    .i_data_bit_clock(data_bit_clock), .i_frame_sync(frame_sync), .i_core_irq(irq), .o_isdn_power_down(pd),
    .o_isdn_clk_en(cke), .o_level_detect_en(), .o_s_tx_en(txe), .o_s_rx_en(rxe),
    .o_s_signal_en(sig), .o_tx_indication(ind), .o_data_bit_clock(),
    .o_data_bit_clock_oe(dclo), .o_frame_sync(), .o_frame_sync_oe(fsco),
    .o_term_bus_en(tbe), .o_upstream_data_line(upl), .o_upstream_data_line_oe(upo),
    .o_chip_reset(), .o_usb_if_reset(), .o_usb_core_reset(ucr), .o_usb_clk_en(),
    .o_pll_en(), .o_core_pll_sel(psel), .o_core_clk_en(cce), .o_osc_en(osc),
    .o_usb_suspended(usus),
    .o_nmi(nmi), .o_nmi_vector(vec), .o_power_state(pst));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_state(input logic [2:0] s);
    for (int n = 0; n < 200 && pst !== s; n++) @(posedge clk);
    check(32'(pst), 32'(s));
  endtask
  // read monitor: each answered read against the oldest note
  always @(posedge clk) begin
    if (rd && wreq === 1'b0) check(rdata, expq.pop_front());
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
  initial begin
    void'($urandom(27));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    check(32'(pst), 32'h0);
    wait_state(3'h1);
    check(32'(usus), 32'h1);
    check(32'(ind), 32'h7);
    rd_exp(ADDR_CMD_CHAN, 32'h7);
    rd_exp(8'hFC, 32'h0);
    $display("test reset done");
    bus(ADDR_CMD_CHAN, 1'b1, 32'(CMD_DEACT_UP));
    settle;
    check(32'(pd), 32'h1);
    check(32'(sig), 32'h0);
    check(32'(ind), 32'hF);
    act <= 1'b1;
    settle;
    check(32'(pd), 32'h0);
    act <= 1'b0;
    r = 4'($urandom % 15);
    bus(ADDR_CMD_CHAN, 1'b1, 32'(r));
    rd_exp(ADDR_CMD_CHAN, 32'(r));
    bus(ADDR_CMD_CHAN, 1'b1, 32'(IND_POWER_UP));
    settle;
    check(32'(pd), 32'h0);
    $display("test command power down done");
    bus(ADDR_ISDN_CTRL, 1'b1, 32'h03);
    settle;
    check(32'(pd), 32'h1);
    check(32'(cke), 32'h1);
    bus(ADDR_ISDN_CTRL, 1'b1, 32'h07);
    settle;
    check(32'(cke), 32'h0);
    bus(ADDR_ISDN_CTRL, 1'b1, 32'h03);
    settle;
    check(32'(cke), 32'h1);
    bus(ADDR_ISDN_CTRL, 1'b1, 32'h10);
    settle;
    check(32'({txe, rxe}), 32'h1);
    bus(ADDR_ISDN_CTRL, 1'b1, 32'h20);
    settle;
    check(32'({rxe, dclo, fsco}), 32'h0);
    bus(ADDR_ISDN_CTRL, 1'b1, 32'h40);
    settle;
    check(32'(tbe), 32'h0);
    bus(ADDR_ISDN_CTRL, 1'b1, 32'h88);
    settle;
    check(32'({upo, upl}), 32'h2);
    act <= 1'b1;
    code <= IND_POWER_UP;
    settle;
    act <= 1'b0;
    rd_exp(ADDR_EVENT, 32'h03);
    bus(ADDR_EVENT, 1'b1, 32'h03);
    bus(ADDR_CMD_CHAN, 1'b1, 32'(CMD_ACT_REQ));
    bus(ADDR_ISDN_CTRL, 1'b1, 32'h00);
    settle;
    check(32'(upo), 32'h0);
    rd_exp(ADDR_EVENT, 32'h00);
    $display("test isdn controls done");
    bus(ADDR_PWR_CTRL, 1'b1, 32'h03);
    bus(ADDR_USB_CTRL, 1'b1, 32'h01);
    bus(ADDR_USB_CTRL, 1'b1, 32'h03);
    settle;
    check(32'(ucr), 32'h1);
    check(32'(psel), 32'h1);
    for (int n = 0; n < 100 && ucr !== 1'b0; n++) @(posedge clk);
    rd_exp(ADDR_USB_CTRL, 32'h05);
    bus(ADDR_USB_CTRL, 1'b1, 32'h09);
    rd_exp(ADDR_USB_CTRL, 32'h01);
    $display("test usb init done");
    bus(ADDR_USB_CTRL, 1'b1, 32'h00);
    bus(ADDR_PWR_CTRL, 1'b1, 32'h01);
    bus(ADDR_PWR_CTRL, 1'b1, 32'h00);
    check(32'(psel), 32'h0);
    bus(ADDR_PWR_CTRL, 1'b1, 32'h04);
    bus(ADDR_PWR_CTRL, 1'b1, 32'h0C);
    wait_state(3'h2);
    check(32'(cce), 32'h0);
    irq <= 1'b1;
    wait_state(3'h1);
    irq <= 1'b0;
    bus(ADDR_PWR_CTRL, 1'b1, 32'h03);
    bus(ADDR_USB_CTRL, 1'b1, 32'h01);
    rd_exp(ADDR_USB_CTRL, 32'h01);
    $display("test idle done");
    bus(ADDR_WAKE_CTRL, 1'b1, 32'h27);
    rxpw <= 1'b0;
    bus(ADDR_PWR_CTRL, 1'b1, 32'h10);
    bus(ADDR_PWR_CTRL, 1'b1, 32'h30);
    wait_state(3'h3);
    check(32'(osc), 32'h0);
    usb_act <= 1'b1;
    settle;
    check(32'(pst), 32'h3);
    check(32'(usus), 32'h0);
    usb_act <= 1'b0;
    pin0_n <= 1'b0;
    wait_state(3'h4);
    pin0_n <= 1'b1;
    for (int n = 0; n < 100 && nmi !== 1'b1; n++) @(posedge clk);
    check(32'(nmi), 32'h1);
    check(32'(vec), 32'h007B);
    wait_state(3'h1);
    rd_exp(ADDR_EVENT, 32'h00);
    $display("test suspend done");
    stop_test;
  end
endmodule
